//--- fifo_flag_map.svh
`ifndef FIFO_FLAG_MAP_SVH
`define FIFO_FLAG_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_LEVEL      8'h08
`define REG_AE_OFS     8'h0C
`define REG_AF_OFS     8'h10
`define REG_IRQ_STAT   8'h14
`define REG_IRQ_MASK   8'h18
// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define CTRL_SYNC_BIT  0
`define CTRL_RTX_BIT   1
`define STAT_BUSY_BIT  5
`define OFS_W          12
`define DATA_W         18
`define IRQ_W          7
`define IRQ_FULL       0
`define IRQ_EMPTY      1
`define IRQ_AE         2
`define IRQ_AF         3
`define IRQ_OVER       4
`define IRQ_UNDER      5
`define IRQ_RTX_DONE   6
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define OFS_RST        12'h007
`define IRQ_RST        7'h00
`define REPLAY_RECOVERY_NS 12
`define CLK_RATE_MHZ   20
`define NS_PER_US      1000
`endif

//--- fifo_flag_pkg.sv
package fifo_flag_pkg;
`include "fifo_flag_map.svh"
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic                half_full_flag_n;
    logic                almost_full_flag_n;
    logic                almost_empty_flag_n;
    logic                empty_flag_n;
    logic                full_flag_n;
  } flags_t;
  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
  } apb_req_t;
  typedef struct packed {
    logic                wr_en;
    logic [`DATA_W-1:0]  data;
  } wr_port_t;
  // ----------------------------------------
  // replay sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    RTX_IDLE    = 3'h1,
    RTX_RECOVER = 3'h2,
    RTX_SETTLE  = 3'h4
  } rtx_state_t;
endpackage : fifo_flag_pkg

//--- fifo_flag_core.sv
`timescale 1ns/10ps
module fifo_flag_core
  import fifo_flag_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // apb slave
  input  wire apb_req_t           apb_req,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // write port
  input  wire wr_port_t           wr_port,
  output logic                    wr_expand_out,
  // read port
  input  wire logic               rd_en,
  input  wire logic               out_disable,
  output logic [`DATA_W-1:0]      q_data,
  output logic                    q_oe_n,
  output logic                    rd_expand_out,
  // flags and interrupt
  output flags_t                  status_flags,
  output logic                    irq
);

  localparam int AW          = $clog2(DEPTH);
  localparam int CW          = AW + 1;
  localparam int LW          = `OFS_W + 1;
  localparam int RTR_CYC_RAW = (`REPLAY_RECOVERY_NS * `CLK_RATE_MHZ + `NS_PER_US - 1) / `NS_PER_US;
  localparam int RTR_CYC     = (RTR_CYC_RAW < 1) ? 1 : RTR_CYC_RAW;
  localparam int RTX_MAX     = 6;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic flags_t flags_of(input logic [LW-1:0] lvl, input logic [`OFS_W-1:0] n_ofs,
                                      input logic [`OFS_W-1:0] m_ofs);
    flags_t          f;
    logic [LW-1:0]   dep;
    dep                   = LW'(DEPTH);
    f.full_flag_n         = (lvl != dep);
    f.empty_flag_n        = (lvl != '0);
    f.almost_empty_flag_n = (lvl > {1'b0, n_ofs});
    f.almost_full_flag_n  = ((lvl + {1'b0, m_ofs}) <= dep);
    f.half_full_flag_n    = (lvl <= (dep >> 1));
    return f;
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    return (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_LEVEL) || (a == `REG_AE_OFS) ||
           (a == `REG_AF_OFS) || (a == `REG_IRQ_STAT) || (a == `REG_IRQ_MASK);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic                   sync_sel_q,  sync_sel_d;
  logic [`OFS_W-1:0]      ae_ofs_q,    ae_ofs_d;
  logic [`OFS_W-1:0]      af_ofs_q,    af_ofs_d;
  logic [`IRQ_W-1:0]      irq_stat_q,  irq_stat_d;
  logic [`IRQ_W-1:0]      irq_mask_q,  irq_mask_d;
  logic [31:0]            prdata_q,    prdata_d;
  logic [AW-1:0]          wr_ptr_q,    wr_ptr_d;
  logic [AW-1:0]          rd_ptr_q,    rd_ptr_d;
  logic [CW-1:0]          count_q,     count_d;
  logic [`DATA_W-1:0]     q_data_q,    q_data_d;
  flags_t                 flags_q,     flags_d;
  logic                   wr_xo_q,     wr_xo_d;
  logic                   rd_xo_q,     rd_xo_d;
  rtx_state_t             rtx_state_q, rtx_state_d;
  logic [3:0]             rtx_cnt_q,   rtx_cnt_d;
  logic                   oe_meta_q;
  logic                   oe_sync_q;
  logic [`DATA_W-1:0]     mem [DEPTH];
  logic                   setup_ph;
  logic                   access_ph;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   rtx_req;
  logic [`IRQ_W-1:0]      irq_evt;
  flags_t                 nf_now;
  flags_t                 nf_prev;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup_ph  = apb_req.psel & ~apb_req.penable;
  assign access_ph = apb_req.psel & apb_req.penable;
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~addr_hit(apb_req.paddr);
  assign prdata    = prdata_q;
  assign rtx_req   = access_ph & apb_req.pwrite & (apb_req.paddr == `REG_CTRL) &
                     apb_req.pwdata[`CTRL_RTX_BIT];

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_comb begin
    logic [`IRQ_W-1:0] clr;
    clr        = '0;
    sync_sel_d = sync_sel_q;
    ae_ofs_d   = ae_ofs_q;
    af_ofs_d   = af_ofs_q;
    irq_mask_d = irq_mask_q;
    prdata_d   = prdata_q;
    if (access_ph && apb_req.pwrite) begin
      case (apb_req.paddr)
        `REG_CTRL:     sync_sel_d = apb_req.pwdata[`CTRL_SYNC_BIT];
        `REG_AE_OFS:   ae_ofs_d   = apb_req.pwdata[`OFS_W-1:0];
        `REG_AF_OFS:   af_ofs_d   = apb_req.pwdata[`OFS_W-1:0];
        `REG_IRQ_STAT: clr        = apb_req.pwdata[`IRQ_W-1:0];
        `REG_IRQ_MASK: irq_mask_d = apb_req.pwdata[`IRQ_W-1:0];
        default:       clr        = '0;
      endcase
    end
    if (setup_ph && !apb_req.pwrite) begin
      case (apb_req.paddr)
        `REG_CTRL:     prdata_d = 32'(sync_sel_q);
        `REG_STATUS:   prdata_d = 32'({(rtx_state_q != RTX_IDLE), flags_q});
        `REG_LEVEL:    prdata_d = 32'(count_q);
        `REG_AE_OFS:   prdata_d = 32'(ae_ofs_q);
        `REG_AF_OFS:   prdata_d = 32'(af_ofs_q);
        `REG_IRQ_STAT: prdata_d = 32'(irq_stat_q);
        `REG_IRQ_MASK: prdata_d = 32'(irq_mask_q);
        default:       prdata_d = '0;
      endcase
    end
    // set wins over a simultaneous clear
    irq_stat_d = (irq_stat_q & ~clr) | irq_evt;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_sel_q <= 1'b0;
      ae_ofs_q   <= `OFS_RST;
      af_ofs_q   <= `OFS_RST;
      irq_stat_q <= `IRQ_RST;
      irq_mask_q <= `IRQ_RST;
      prdata_q   <= '0;
    end else begin
      sync_sel_q <= sync_sel_d;
      ae_ofs_q   <= ae_ofs_d;
      af_ofs_q   <= af_ofs_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      prdata_q   <= prdata_d;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------
  // storage array
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (wr_acc) begin
      mem[wr_ptr_q] <= wr_port.data;
    end
  end

  // ----------------------------------------
  // pointers, level, flags, replay
  // ----------------------------------------
  assign wr_acc = wr_port.wr_en & (count_q != CW'(DEPTH));
  assign rd_acc = rd_en & (count_q != '0) & (rtx_state_q == RTX_IDLE) & ~rtx_req;

  always_comb begin
    wr_ptr_d    = wr_acc ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
    rd_ptr_d    = rd_acc ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
    q_data_d    = rd_acc ? mem[rd_ptr_q] : q_data_q;
    wr_xo_d     = wr_acc && (wr_ptr_q == AW'(DEPTH - 1));
    rd_xo_d     = rd_acc && (rd_ptr_q == AW'(DEPTH - 1));
    rtx_state_d = rtx_state_q;
    rtx_cnt_d   = rtx_cnt_q;
    case ({wr_acc, rd_acc})
      2'b10:   count_d = CW'(count_q + 1'b1);
      2'b01:   count_d = CW'(count_q - 1'b1);
      default: count_d = count_q;
    endcase
    case (rtx_state_q)
      RTX_IDLE: begin
        if (rtx_req) begin
          rd_ptr_d    = '0;
          count_d     = CW'(wr_ptr_q) + CW'(wr_acc);
          rtx_cnt_d   = 4'(RTR_CYC);
          rtx_state_d = RTX_RECOVER;
        end
      end
      RTX_RECOVER: begin
        rtx_cnt_d = 4'(rtx_cnt_q - 1'b1);
        if (rtx_cnt_q <= 4'h1) begin
          rtx_state_d = RTX_SETTLE;
        end
      end
      RTX_SETTLE: begin
        rtx_state_d = RTX_IDLE;
      end
      default: begin
        rtx_state_d = RTX_IDLE;
      end
    endcase
    nf_now  = flags_of(LW'(count_d), ae_ofs_q, af_ofs_q);
    nf_prev = flags_of(LW'(count_q), ae_ofs_q, af_ofs_q);
    // full/empty move at the edge of the operation
    flags_d.full_flag_n      = nf_now.full_flag_n;
    flags_d.empty_flag_n     = nf_now.empty_flag_n;
    flags_d.half_full_flag_n = nf_now.half_full_flag_n;
    if (!sync_sel_q) begin
      flags_d.almost_empty_flag_n = nf_now.almost_empty_flag_n;
      flags_d.almost_full_flag_n  = nf_now.almost_full_flag_n;
    end else if (rtx_state_q == RTX_RECOVER) begin
      flags_d.almost_empty_flag_n = flags_q.almost_empty_flag_n;
      flags_d.almost_full_flag_n  = flags_q.almost_full_flag_n;
    end else begin
      flags_d.almost_empty_flag_n = nf_prev.almost_empty_flag_n;
      flags_d.almost_full_flag_n  = nf_prev.almost_full_flag_n;
    end
    irq_evt               = '0;
    irq_evt[`IRQ_FULL]    = flags_q.full_flag_n & ~flags_d.full_flag_n;
    irq_evt[`IRQ_EMPTY]   = flags_q.empty_flag_n & ~flags_d.empty_flag_n;
    irq_evt[`IRQ_AE]      = flags_q.almost_empty_flag_n & ~flags_d.almost_empty_flag_n;
    irq_evt[`IRQ_AF]      = flags_q.almost_full_flag_n & ~flags_d.almost_full_flag_n;
    irq_evt[`IRQ_OVER]    = wr_port.wr_en & ~wr_acc;
    irq_evt[`IRQ_UNDER]   = rd_en & (count_q == '0);
    irq_evt[`IRQ_RTX_DONE] = (rtx_state_q == RTX_SETTLE);
  end

  // clocks may run during reset; everything holds constants until release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      count_q     <= '0;
      q_data_q    <= '0;
      flags_q     <= flags_t'({1'b1, 1'b1, 1'b0, 1'b0, 1'b1});
      wr_xo_q     <= 1'b0;
      rd_xo_q     <= 1'b0;
      rtx_state_q <= RTX_IDLE;
      rtx_cnt_q   <= '0;
    end else begin
      wr_ptr_q    <= wr_ptr_d;
      rd_ptr_q    <= rd_ptr_d;
      count_q     <= count_d;
      q_data_q    <= q_data_d;
      flags_q     <= flags_d;
      wr_xo_q     <= wr_xo_d;
      rd_xo_q     <= rd_xo_d;
      rtx_state_q <= rtx_state_d;
      rtx_cnt_q   <= rtx_cnt_d;
    end
  end

  // ----------------------------------------
  // output disable pin sync
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_meta_q <= 1'b1;
      oe_sync_q <= 1'b1;
    end else begin
      oe_meta_q <= out_disable;
      oe_sync_q <= oe_meta_q;
    end
  end

  assign q_data        = q_data_q;
  assign q_oe_n        = oe_sync_q;
  assign status_flags  = flags_q;
  assign wr_expand_out = wr_xo_q;
  assign rd_expand_out = rd_xo_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_fill_last;
    wr_acc && !rd_acc && (count_q == CW'(DEPTH - 1));
  endsequence

  sequence s_first_word;
    (!flags_q.empty_flag_n && wr_acc) ##1 (rd_acc && !wr_acc);
  endsequence

  property p_full_set;
    @(posedge ref_clk) disable iff (!reset_n) s_fill_last |=> !status_flags.full_flag_n;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag not set on last write");

  property p_full_clear;
    @(posedge ref_clk) disable iff (!reset_n)
      (!status_flags.full_flag_n && rd_acc && !wr_acc) |=> status_flags.full_flag_n;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full flag not cleared by read");

  property p_empty_clear;
    @(posedge ref_clk) disable iff (!reset_n)
      (!status_flags.empty_flag_n && wr_acc && rtx_state_q == RTX_IDLE) |=> status_flags.empty_flag_n;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("empty flag not cleared by write");

  property p_first_word;
    @(posedge ref_clk) disable iff (!reset_n) s_first_word |=> (q_data == $past(wr_port.data, 2));
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not presented");

  property p_reset_out;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(reset_n) |-> (q_data == '0) ##2 (q_oe_n == $past(out_disable, 2));
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");

  property p_ae_set;
    @(posedge ref_clk) disable iff (!reset_n)
      (!sync_sel_q && rd_acc && !wr_acc && count_q == CW'(ae_ofs_q) + 1'b1)
      |=> (!status_flags.almost_empty_flag_n && count_q == CW'(ae_ofs_q));
  endproperty
  a_ae_set: assert property (p_ae_set) else $error("almost-empty not set at offset");

  property p_af_set;
    @(posedge ref_clk) disable iff (!reset_n)
      (!sync_sel_q && wr_acc && !rd_acc && (LW'(count_q) + {1'b0, af_ofs_q}) == LW'(DEPTH))
      |=> !status_flags.almost_full_flag_n;
  endproperty
  a_af_set: assert property (p_af_set) else $error("almost-full not set at offset");

  property p_wr_xo;
    @(posedge ref_clk) disable iff (!reset_n)
      (wr_acc && wr_ptr_q == AW'(DEPTH - 1)) |=> wr_expand_out ##1 !wr_expand_out;
  endproperty
  a_wr_xo: assert property (p_wr_xo) else $error("write expansion pulse missing");

  property p_rd_xo;
    @(posedge ref_clk) disable iff (!reset_n)
      rd_expand_out |-> ($past(rd_acc) && $past(rd_ptr_q) == AW'(DEPTH - 1) && rd_ptr_q == '0);
  endproperty
  a_rd_xo: assert property (p_rd_xo) else $error("read expansion pulse wrong");

  property p_rtx_bound;
    @(posedge ref_clk) disable iff (!reset_n)
      (rtx_req && rtx_state_q == RTX_IDLE) |=> ##[1:RTX_MAX] (rtx_state_q == RTX_IDLE &&
        status_flags.empty_flag_n == (count_q != '0));
  endproperty
  a_rtx_bound: assert property (p_rtx_bound) else $error("flags not valid after replay");

endmodule // fifo_flag_core

//--- stream_partner.sv
`timescale 1ns/10ps
// ----------------------------------------
// writer and reader logic on the far side
// ----------------------------------------
module stream_partner
  import fifo_flag_pkg::*;
#(
  parameter logic [17:0] BASE = 18'h15A00
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // commands from the bench
  input  wire logic wr_req,
  input  wire logic rd_req,
  // fifo side
  output wr_port_t  wr_port,
  output logic      rd_en
);
  logic [17:0] cnt_q;
  logic [17:0] cnt_d;
  logic [17:0] last_q;
  logic [17:0] last_d;

  always_comb begin
    cnt_d  = wr_req ? cnt_q + 18'h00001 : cnt_q;
    last_d = wr_req ? BASE + cnt_q : last_q;
  end

  // clocks keep running while reset is held
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= 18'h00000;
      last_q <= 18'h00000;
    end else begin
      cnt_q  <= cnt_d;
      last_q <= last_d;
    end
  end

  // one shared clock, so edge spacing always meets the skew minima
  always_comb begin
    wr_port.wr_en = wr_req;
    wr_port.data  = wr_req ? BASE + cnt_q : ~last_q;
    rd_en         = rd_req;
  end
endmodule // stream_partner

//--- tb_top.sv
`timescale 1ns/10ps
`include "fifo_flag_map.svh"
module tb_top
  import fifo_flag_pkg::*;
;
  localparam int          DEPTH = 16;
  localparam logic [17:0] BASE  = 18'h15A00;
  typedef struct packed {
    logic [7:0] lvl;
    logic [4:0] flg;
  } row_t;

  logic        ref_clk;
  logic        reset_n;
  logic        wr_req;
  logic        rd_req;
  logic        out_disable;
  apb_req_t    apb_q;
  wr_port_t    wr_port;
  logic        rd_en;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wr_expand_out;
  logic [17:0] q_data;
  logic        q_oe_n;
  logic        rd_expand_out;
  flags_t      status_flags;
  logic        irq;
  logic [31:0] rd_v;
  logic        err_v;
  row_t        rows [7];
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          cnt;

  fifo_flag_core #(.DEPTH(DEPTH)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .apb_req(apb_q), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr_port(wr_port), .wr_expand_out(wr_expand_out), .rd_en(rd_en),
    .out_disable(out_disable), .q_data(q_data), .q_oe_n(q_oe_n), .rd_expand_out(rd_expand_out),
    .status_flags(status_flags), .irq(irq));

  stream_partner #(.BASE(BASE)) partner (
    .ref_clk(ref_clk), .reset_n(reset_n), .wr_req(wr_req), .rd_req(rd_req),
    .wr_port(wr_port), .rd_en(rd_en));

  // ----------------------------------------
  // clock and timeout
  // ----------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apb_q <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apb_q.penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1) @(posedge ref_clk);
    rd_v = prdata;
    err_v = pslverr;
    apb_q.psel <= 1'h0;
    apb_q.penable <= 1'h0;
  endtask

  task automatic push();
    @(posedge ref_clk);
    wr_req <= 1'h1;
    @(posedge ref_clk);
    wr_req <= 1'h0;
    @(negedge ref_clk);
  endtask

  task automatic pop();
    @(posedge ref_clk);
    rd_req <= 1'h1;
    @(posedge ref_clk);
    rd_req <= 1'h0;
    @(negedge ref_clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'h0;
    wr_req = 1'h0;
    rd_req = 1'h0;
    out_disable = 1'h0;
    apb_q = '0;
    rows = '{'{8'h00, 5'h19}, '{8'h01, 5'h1B}, '{8'h07, 5'h1B}, '{8'h08, 5'h1F},
             '{8'h09, 5'h0F}, '{8'h0A, 5'h07}, '{8'h10, 5'h06}};
    repeat (12) @(posedge ref_clk);
    chk("q_oe_n in reset", 32'h1, 32'(q_oe_n));
    chk("flags in reset", 32'h19, 32'(status_flags));
    reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("q_oe_n enabled", 32'h0, 32'(q_oe_n));
    chk("q_data low", 32'h0, 32'(q_data));
    @(posedge ref_clk);
    out_disable <= 1'h1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("q_oe_n disabled", 32'h1, 32'(q_oe_n));
    @(posedge ref_clk);
    out_disable <= 1'h0;
    apb(1'h0, `REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd_v);
    apb(1'h0, `REG_AE_OFS, 32'h0);
    chk("ae offset reset", 32'h7, rd_v);
    apb(1'h0, `REG_AF_OFS, 32'h0);
    chk("af offset reset", 32'h7, rd_v);
    apb(1'h0, `REG_IRQ_MASK, 32'h0);
    chk("irq mask reset", 32'h0, rd_v);
    apb(1'h1, 8'h1C, 32'hFFFFFFFF);
    apb(1'h0, 8'h1C, 32'h0);
    chk("unmapped data", 32'h0, rd_v);
    chk("unmapped error", 32'h1, 32'(err_v));
    // fill through the table rows
    cnt = 0;
    for (int r = 0; r < 7; r++) begin
      while (cnt < int'(rows[r].lvl)) begin
        push();
        cnt++;
        chk("wr_expand_out", 32'(cnt == DEPTH), 32'(wr_expand_out));
      end
      chk("flags on fill", 32'(rows[r].flg), 32'(status_flags));
      apb(1'h0, `REG_LEVEL, 32'h0);
      chk("level on fill", 32'(rows[r].lvl), rd_v);
    end
    // write while full, then interrupt mask and clear
    push();
    apb(1'h1, `REG_IRQ_MASK, 32'h10);
    @(negedge ref_clk);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'h1, `REG_IRQ_STAT, 32'h10);
    apb(1'h0, `REG_IRQ_STAT, 32'h0);
    chk("over bit cleared", 32'h0, rd_v & 32'h10);
    chk("irq cleared", 32'h0, 32'(irq));
    // drain through the table rows, data in order
    for (int r = 5; r >= 0; r--) begin
      while (cnt > int'(rows[r].lvl)) begin
        pop();
        chk("q_data", 32'(BASE + 18'(DEPTH - cnt)), 32'(q_data));
        chk("rd_expand_out", 32'(cnt == 1), 32'(rd_expand_out));
        cnt--;
      end
      chk("flags on drain", 32'(rows[r].flg), 32'(status_flags));
    end
    pop();
    apb(1'h0, `REG_IRQ_STAT, 32'h0);
    chk("under bit set", 32'h20, rd_v & 32'h20);
    // second reset, then first-word latency at the empty boundary
    @(posedge ref_clk);
    reset_n <= 1'h0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    wr_req <= 1'h1;
    @(posedge ref_clk);
    wr_req <= 1'h0;
    rd_req <= 1'h1;
    @(negedge ref_clk);
    chk("empty cleared", 32'h1, 32'(status_flags.empty_flag_n));
    @(posedge ref_clk);
    rd_req <= 1'h0;
    @(negedge ref_clk);
    chk("first word", 32'(BASE), 32'(q_data));
    chk("empty again", 32'h0, 32'(status_flags.empty_flag_n));
    // replay from location zero
    repeat (3) push();
    repeat (2) pop();
    apb(1'h1, `REG_CTRL, 32'h2);
    apb(1'h0, `REG_STATUS, 32'h0);
    chk("status busy in replay", 32'h3B, rd_v);
    repeat (4) @(posedge ref_clk);
    apb(1'h0, `REG_LEVEL, 32'h0);
    chk("level after replay", 32'h4, rd_v);
    chk("flags after replay", 32'h1B, 32'(status_flags));
    apb(1'h0, `REG_IRQ_STAT, 32'h0);
    chk("replay done bit", 32'h40, rd_v & 32'h40);
    pop();
    chk("replayed word", 32'(BASE), 32'(q_data));
    // sync flag mode, almost-empty lags one edge
    apb(1'h1, `REG_CTRL, 32'h1);
    repeat (5) push();
    chk("sync ae lag", 32'h0, 32'(status_flags.almost_empty_flag_n));
    @(negedge ref_clk);
    chk("sync ae update", 32'h1, 32'(status_flags.almost_empty_flag_n));
    // replay in sync flag mode: almost-empty held through recovery
    repeat (2) pop();
    apb(1'h1, `REG_CTRL, 32'h3);
    repeat (2) @(negedge ref_clk);
    chk("sync ae held in replay", 32'h0, 32'(status_flags.almost_empty_flag_n));
    @(negedge ref_clk);
    chk("sync ae after replay", 32'h1, 32'(status_flags.almost_empty_flag_n));
    finish_test();
  end
endmodule // tb_top
